// File: verilog/config_word_defines.vh
// Constants for the configuration word decoder: map, fields, encodings
//
// Overview of operation
// - Word one sits at configuration index 8007h, word two at 8008h, apart from data.
// - Unimplemented bits, bit 8 of word one included, read one; blank or erased reads one.
// - Fail monitor bit one enables monitor and switchover; zero disables the monitor.
// - Switchover bit one enables internal/offchip switchover; zero disables it unless the fail monitor bit is one.
// - Crystal modes ignore clock out bit, pin stays oscillator; else one is I/O, zero clock.
// - Brownout field: 11 on, 10 on while running, 01 software bit, 00 off.
// - Readout guard zero turns program memory code protection on; one turns it off.
// - Single supply programming one ignores pin select; else one reset pin, zero input.
// - Power-up delay bit zero enables the power-up timer; one disables it.
// - Watchdog field: 11 on, 10 on while running, 01 software bit, 00 off.
// - Oscillator 111, 110, 101 select offchip clock input at high, medium, low power.
// - Oscillator 100 onchip fast osc, 011 offchip RC, 010/001/000 fast, standard, slow crystal.
// - Protection off during erase wipes program memory; bulk erase wipes program and configuration.
// - Single supply programming one enables low-voltage programming; zero needs high voltage.
`ifndef CONFIG_WORD_DEFINES_VH
`define CONFIG_WORD_DEFINES_VH

// Register indexes and byte addresses
`define CW_ADDR_W 20
`define CW1_INDEX 20'h0_8007
`define CW2_INDEX 20'h0_8008
// Shift keeps the byte address at the bus address width
`define CW1_ADDR (`CW1_INDEX << 2)
`define CW2_ADDR (`CW2_INDEX << 2)
`define CTRL_ADDR 20'h0_0000
`define STAT_ADDR 20'h0_0004

// Word layout
`define CW_W 14
`define CW_BLANK 14'h3_FFF
`define CW1_UNIMPL 14'h0_100
`define CW2_UNIMPL 14'h0_078
`define CW1_FCM 13
`define CW1_SWITCHOVER 12
`define CW1_CKO 11
`define CW1_BOR_HI 10
`define CW1_BOR_LO 9
`define CW1_GUARD 7
`define CW1_RSTPIN 6
`define CW1_PWRUP 5
`define CW1_WDT_HI 4
`define CW1_WDT_LO 3
`define CW1_OSC_HI 2
`define CW2_SINGLE_SUPPLY 13
`define CW2_DBG 12

// Two-bit enable field encodings
`define EN_ALWAYS 2'h3
`define EN_RUN_ONLY 2'h2
`define EN_SOFTWARE 2'h1
`define EN_OFF 2'h0

// Oscillator encodings
`define OSC_OFFCHIP_HIGH 3'h7
`define OSC_OFFCHIP_MID 3'h6
`define OSC_OFFCHIP_LOW 3'h5
`define OSC_ONCHIP_HF 3'h4
`define OSC_OFFCHIP_RC 3'h3
`define OSC_FAST_XTAL 3'h2
`define OSC_XTAL 3'h1
`define OSC_SLOW_XTAL 3'h0

// Control register bits
`define CTRL_SW_WDT 0
`define CTRL_SW_BOR 1
`define CTRL_A3_PU 2
`define CTRL_RELOAD 3
`define CTRL_RESET 4'h0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/config_nv_store.v
// Nonvolatile store for the two configuration words
`timescale 1ns/1ps
`default_nettype none
`include "config_word_defines.vh"

module config_nv_store
(
  input wire aclk,
  input wire nv_blank,
  input wire bulk_erase,
  input wire wr_en,
  input wire wr_sel,
  input wire [`CW_W-1:0] wr_data,
  output wire [`CW_W-1:0] word_one,
  output wire [`CW_W-1:0] word_two
);

  reg [`CW_W-1:0] mem [0:1];

  ////////////////////////////////////////////////////////////////////////////
  // Not cleared by aresetn: contents must survive a device reset
  always @(posedge aclk)
  begin
    if (nv_blank || bulk_erase)
    begin
      mem[0] <= `CW_BLANK;
      mem[1] <= `CW_BLANK;
    end
    else if (wr_en)
    begin
      mem[wr_sel] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unimplemented cells always read one
  assign word_one = mem[0] | `CW1_UNIMPL;
  assign word_two = mem[1] | `CW2_UNIMPL;

endmodule // config_nv_store
`default_nettype wire

// File: verilog/config_word_decoder.v
// Configuration word decoder with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "config_word_defines.vh"

module config_word_decoder
(
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [`CW_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`CW_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Programmer side
  input wire nv_blank,
  input wire prog_wr_en,
  input wire prog_wr_sel,
  input wire [`CW_W-1:0] prog_wr_data,
  input wire prog_bulk_erase,
  input wire prog_unprotect_erase,
  // Core state
  input wire cpu_sleep,
  // Decoded settings
  output reg clock_fail_monitor_on,
  output reg switchover_on,
  output reg clock_output_pin_drives_clock,
  output reg clock_output_pin_is_io,
  output reg clock_output_pin_is_osc,
  output reg brownout_active,
  output reg watchdog_active,
  output reg code_protect_on,
  output reg master_reset_pin_is_reset,
  output reg master_reset_pin_pullup,
  output reg powerup_delay_timer_on,
  output reg low_voltage_prog_on,
  output reg debugger_on,
  output reg [7:0] osc_mode_onehot,
  output reg program_mem_erase,
  output reg settings_valid
);

  // One-hot sequencer states
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CW_W-1:0] latched_one;
  reg [`CW_W-1:0] latched_two;
  reg [3:0] ctrl;
  reg [`CW_ADDR_W-1:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire [`CW_W-1:0] word_one;
  wire [`CW_W-1:0] word_two;
  wire [3:0] wsel;
  wire [3:0] rsel;
  wire do_write;
  wire reload;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode: one-hot {status, ctrl, word two, word one}
  function [3:0] reg_decode;
    input [`CW_ADDR_W-1:0] addr;
    begin
      reg_decode = 4'h0;
      case (addr)
        `CW1_ADDR: reg_decode = 4'h1;
        `CW2_ADDR: reg_decode = 4'h2;
        `CTRL_ADDR: reg_decode = 4'h4;
        `STAT_ADDR: reg_decode = 4'h8;
        default: reg_decode = 4'h0;
      endcase
    end
  endfunction

  // Two-bit enable fields share one decoding
  function en_field;
    input [1:0] field;
    input sleeping;
    input sw_bit;
    begin
      case (field)
        `EN_ALWAYS: en_field = 1'b1;
        `EN_RUN_ONLY: en_field = ~sleeping;
        `EN_SOFTWARE: en_field = sw_bit;
        default: en_field = 1'b0;
      endcase
    end
  endfunction

  assign wsel = reg_decode(aw_addr);
  assign rsel = reg_decode(s_axi_araddr);
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign reload = do_write && wsel[2] && w_strb[0] && w_data[`CTRL_RELOAD];

  ////////////////////////////////////////////////////////////////////////////
  // Word storage, erased in place by the programmer
  config_nv_store u_store
  (
    .aclk(aclk),
    .nv_blank(nv_blank),
    .bulk_erase(prog_bulk_erase),
    .wr_en(prog_wr_en),
    .wr_sel(prog_wr_sel),
    .wr_data(prog_wr_data),
    .word_one(word_one),
    .word_two(word_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: load after reset and on each reload request, otherwise hold static
  always @*
  begin
    next_state = state;
    case (state)
      ST_HOLD: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_RUN;
      ST_RUN: next_state = reload ? ST_LOAD : ST_RUN;
      default: next_state = ST_HOLD;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  // Snapshot of the words; later programming has no effect until reload or reset
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latched_one <= `CW_BLANK;
      latched_two <= `CW_BLANK;
      settings_valid <= 1'b0;
    end
    else if (state == ST_LOAD)
    begin
      latched_one <= word_one;
      latched_two <= word_two;
      settings_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded outputs, registered from the snapshot
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_fail_monitor_on <= 1'b0;
      switchover_on <= 1'b0;
      clock_output_pin_drives_clock <= 1'b0;
      clock_output_pin_is_io <= 1'b0;
      clock_output_pin_is_osc <= 1'b0;
      brownout_active <= 1'b0;
      watchdog_active <= 1'b0;
      code_protect_on <= 1'b0;
      master_reset_pin_is_reset <= 1'b0;
      master_reset_pin_pullup <= 1'b0;
      powerup_delay_timer_on <= 1'b0;
      low_voltage_prog_on <= 1'b0;
      debugger_on <= 1'b0;
      osc_mode_onehot <= 8'h00;
    end
    else
    begin
      clock_fail_monitor_on <= latched_one[`CW1_FCM];
      // Monitor on also forces switchover on
      switchover_on <= latched_one[`CW1_SWITCHOVER] | latched_one[`CW1_FCM];
      // Crystal modes need the pin for the oscillator
      if (latched_one[`CW1_OSC_HI:0] <= `OSC_FAST_XTAL)
      begin
        clock_output_pin_is_osc <= 1'b1;
        clock_output_pin_is_io <= 1'b0;
        clock_output_pin_drives_clock <= 1'b0;
      end
      else
      begin
        clock_output_pin_is_osc <= 1'b0;
        clock_output_pin_is_io <= latched_one[`CW1_CKO];
        clock_output_pin_drives_clock <= ~latched_one[`CW1_CKO];
      end
      brownout_active <= en_field(latched_one[`CW1_BOR_HI:`CW1_BOR_LO], cpu_sleep,
        ctrl[`CTRL_SW_BOR]);
      watchdog_active <= en_field(latched_one[`CW1_WDT_HI:`CW1_WDT_LO], cpu_sleep,
        ctrl[`CTRL_SW_WDT]);
      code_protect_on <= ~latched_one[`CW1_GUARD];
      // With low-voltage programming the pin stays a reset pin
      if (latched_two[`CW2_SINGLE_SUPPLY])
      begin
        master_reset_pin_is_reset <= 1'b1;
        master_reset_pin_pullup <= 1'b1;
      end
      else
      begin
        master_reset_pin_is_reset <= latched_one[`CW1_RSTPIN];
        master_reset_pin_pullup <= latched_one[`CW1_RSTPIN] | ctrl[`CTRL_A3_PU];
      end
      powerup_delay_timer_on <= ~latched_one[`CW1_PWRUP];
      low_voltage_prog_on <= latched_two[`CW2_SINGLE_SUPPLY];
      // Bit is left to the tools; zero turns the debugger on
      debugger_on <= ~latched_two[`CW2_DBG];
      osc_mode_onehot <= 8'h01 << latched_one[`CW1_OSC_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase of program memory: bulk erase or protection being turned off
  always @(posedge aclk)
  begin
    if (!aresetn)
      program_mem_erase <= 1'b0;
    else
      program_mem_erase <= prog_bulk_erase | prog_unprotect_erase;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channels taken in either order, answered once both are held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`CW_ADDR_W{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        // Only the control word is writable; config words refuse with an error
        if (wsel[2])
        begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_strb[0])
            ctrl <= {1'b0, w_data[2:0]};
        end
        else
          s_axi_bresp <= `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, data registered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rsel == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
      case (rsel)
        4'h1: s_axi_rdata <= {18'h0_0000, word_one};
        4'h2: s_axi_rdata <= {18'h0_0000, word_two};
        4'h4: s_axi_rdata <= {28'h000_0000, ctrl};
        4'h8: s_axi_rdata <= {24'h00_0000, osc_mode_onehot} |
          {16'h0000, settings_valid, code_protect_on, brownout_active, watchdog_active,
          low_voltage_prog_on, clock_fail_monitor_on, switchover_on, powerup_delay_timer_on, 8'h00};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // config_word_decoder
`default_nettype wire

// File: tb/config_word_checker_props.sv
// Port assertions for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module config_word_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic prog_bulk_erase,
  input wire logic prog_unprotect_erase,
  input wire logic program_mem_erase,
  input wire logic settings_valid,
  input wire logic clock_fail_monitor_on,
  input wire logic switchover_on,
  input wire logic clock_output_pin_drives_clock,
  input wire logic clock_output_pin_is_io,
  input wire logic clock_output_pin_is_osc,
  input wire logic [7:0] osc_mode_onehot,
  input wire logic master_reset_pin_is_reset,
  input wire logic master_reset_pin_pullup,
  input wire logic low_voltage_prog_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Handshake steps of the register bus, and the erase request
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence erase_req;
    $rose(prog_bulk_erase) || $rose(prog_unprotect_erase);
  endsequence
  ////////////////////////////////////////////////////////////////
  // Held address and data are answered two cycles after being taken
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_erase_pulse: assert property (erase_req |=> program_mem_erase ##1 !program_mem_erase)
    else $error("erase pulse wrong");
  a_valid_stays: assert property (settings_valid |=> settings_valid) else $error("settings lost");
  a_osc_onehot: assert property ($past(settings_valid) |-> $onehot(osc_mode_onehot))
    else $error("oscillator mode not one-hot");
  a_pin_onehot: assert property ($past(settings_valid) |->
    $onehot({clock_output_pin_drives_clock, clock_output_pin_is_io, clock_output_pin_is_osc}))
    else $error("clock pin function not unique");
  a_xtal_pin: assert property (|osc_mode_onehot[2:0] |-> clock_output_pin_is_osc)
    else $error("crystal pin not oscillator");
  a_fcm_switch: assert property (clock_fail_monitor_on |-> switchover_on) else $error("monitor without switchover");
  a_lvp_pin: assert property (low_voltage_prog_on |-> master_reset_pin_is_reset && master_reset_pin_pullup)
    else $error("reset pin not kept under low-voltage programming");
endmodule // config_word_checker
bind config_word_decoder config_word_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .prog_bulk_erase, .prog_unprotect_erase, .program_mem_erase, .settings_valid,
  .clock_fail_monitor_on, .switchover_on, .clock_output_pin_drives_clock, .clock_output_pin_is_io,
  .clock_output_pin_is_osc, .osc_mode_onehot, .master_reset_pin_is_reset, .master_reset_pin_pullup,
  .low_voltage_prog_on);
`default_nettype wire

// File: tb/cfg_programmer.sv
// Programmer model feeding the configuration store
`timescale 1ns/1ps
`default_nettype none
module cfg_programmer
(
  input wire logic aclk,
  output var logic nv_blank,
  output var logic prog_wr_en,
  output var logic prog_wr_sel,
  output var logic [13:0] prog_wr_data,
  output var logic prog_bulk_erase,
  output var logic prog_unprotect_erase
);
  // Idle at time zero
  initial
  begin
    {nv_blank, prog_wr_en, prog_wr_sel, prog_bulk_erase, prog_unprotect_erase} = 5'h00;
    prog_wr_data = 14'h0000;
  end
  // One word write; data line is scrambled afterwards so stale values never pass
  task automatic put(input logic sel, input logic [13:0] d);
    @(posedge aclk);
    prog_wr_sel <= sel;
    prog_wr_data <= sel ? (d | 14'h1000) : d;
    prog_wr_en <= 1'h1;
    @(posedge aclk);
    prog_wr_en <= 1'h0;
    prog_wr_data <= ~d;
  endtask
  // One-cycle pulse on blank, bulk erase or unprotect erase
  task automatic pulse(input logic [2:0] k);
    @(posedge aclk);
    {nv_blank, prog_bulk_erase, prog_unprotect_erase} <= k;
    @(posedge aclk);
    {nv_blank, prog_bulk_erase, prog_unprotect_erase} <= 3'h0;
  endtask
endmodule // cfg_programmer
`default_nettype wire

// File: tb/config_word_decoder_tb_top.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
`include "config_word_defines.vh"
module config_word_decoder_tb_top;
  localparam logic [19:0] a_w1 = 20'(`CW1_ADDR);
  localparam logic [19:0] a_w2 = 20'(`CW2_ADDR);
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic cpu_sleep = 1'h0;
  logic [19:0] s_axi_awaddr = 20'h0_0000, s_axi_araddr = 20'h0_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic nv_blank, prog_wr_en, prog_wr_sel, prog_bulk_erase, prog_unprotect_erase;
  logic [13:0] prog_wr_data, w1, w2, p1, p2;
  logic clock_fail_monitor_on, switchover_on, clock_output_pin_drives_clock, clock_output_pin_is_io;
  logic clock_output_pin_is_osc, brownout_active, watchdog_active, code_protect_on, master_reset_pin_is_reset;
  logic master_reset_pin_pullup, powerup_delay_timer_on, low_voltage_prog_on, debugger_on;
  logic program_mem_erase, settings_valid, sl, slow_rr;
  logic [7:0] osc_mode_onehot;
  logic [31:0] d;
  logic [2:0] c, pc;
  int bad_count = 0, check_count = 0, seed = 32'h0994;
  config_word_decoder dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_blank,
    .prog_wr_en, .prog_wr_sel, .prog_wr_data, .prog_bulk_erase, .prog_unprotect_erase, .cpu_sleep,
    .clock_fail_monitor_on, .switchover_on, .clock_output_pin_drives_clock, .clock_output_pin_is_io,
    .clock_output_pin_is_osc, .brownout_active, .watchdog_active, .code_protect_on, .master_reset_pin_is_reset,
    .master_reset_pin_pullup, .powerup_delay_timer_on, .low_voltage_prog_on, .debugger_on, .osc_mode_onehot,
    .program_mem_erase, .settings_valid);
  cfg_programmer prog_u (.aclk, .nv_blank, .prog_wr_en, .prog_wr_sel, .prog_wr_data, .prog_bulk_erase,
    .prog_unprotect_erase);
  // 25 MHz clock
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [19:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 60);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 60) bad_count++;
  endtask
  task automatic rd(input logic [19:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= {1'h1, !slow_rr};
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      // Late ready leaves the answer waiting one cycle
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 60);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 60) bad_count++;
  endtask
  ////////////////////////////////////////////////////////////////
  // Two-bit enable field against sleep and software bit
  function automatic logic en(input logic [1:0] f, input logic s, input logic sw);
    return f == `EN_ALWAYS || (f == `EN_RUN_ONLY && !s) || (f == `EN_SOFTWARE && sw);
  endfunction
  function automatic logic [31:0] stat(input logic [13:0] a, input logic [13:0] b, input logic [2:0] k,
    input logic s);
    return {16'h0000, 1'h1, ~a[7], en(a[10:9], s, k[1]), en(a[4:3], s, k[0]), b[13], a[13],
      a[13] | a[12], ~a[5], 8'h01 << a[2:0]};
  endfunction
  function automatic logic [5:0] pins(input logic [13:0] a, input logic [13:0] b, input logic [2:0] k);
    logic o;
    o = a[2:0] <= `OSC_FAST_XTAL;
    return {o, !o && a[11], !o && !a[11], b[13] | a[6], b[13] | a[6] | k[2], ~b[12]};
  endfunction
  task automatic reload();
    wr(`CTRL_ADDR, {29'h0000_0001, c}, 4'h1);
    check("ctrl_resp", r, `RESP_OKAY);
    repeat (3) @(posedge aclk);
  endtask
  task results();
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    prog_u.pulse(3'h4);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    p1 = `CW_BLANK;
    p2 = `CW_BLANK;
    pc = 3'h0;
    for (int i = 0; i < 16; i++)
    begin
      w1 = 14'($random(seed));
      w2 = 14'($random(seed)) | 14'h1000;
      {w1[10:9], w1[4:3], w1[2:0]} = {i[1:0], i[3:2], i[2:0]};
      {sl, c, slow_rr} = 5'($random(seed));
      prog_u.put(1'h0, w1);
      prog_u.put(1'h1, w2);
      cpu_sleep <= sl;
      rd(a_w1);
      check("word_one", d, {18'h0_0000, w1 | `CW1_UNIMPL});
      rd(a_w2);
      check("word_two", d, {18'h0_0000, w2 | `CW2_UNIMPL});
      rd(`STAT_ADDR);
      check("status_held", d, stat(p1, p2, pc, sl));
      reload();
      check("pins", {clock_output_pin_is_osc, clock_output_pin_is_io, clock_output_pin_drives_clock,
        master_reset_pin_is_reset, master_reset_pin_pullup, debugger_on}, pins(w1, w2, c));
      rd(`STAT_ADDR);
      check("status", d, stat(w1, w2, c, sl));
      {p1, p2, pc} = {w1, w2, c};
    end
    // Refused accesses: read-only word, unmapped place; empty strobe accepted but ignored
    wr(a_w1, 32'h0000_0000, 4'hF);
    check("ro_resp", r, `RESP_SLVERR);
    rd(a_w1);
    check("ro_keep", d, {18'h0_0000, p1 | `CW1_UNIMPL});
    rd(20'h0_0010);
    check("unmapped_resp", r, `RESP_SLVERR);
    check("unmapped_data", d, 32'h0000_0000);
    wr(`CTRL_ADDR, 32'h0000_0000, 4'h0);
    check("empty_strb_resp", r, `RESP_OKAY);
    rd(`CTRL_ADDR);
    check("ctrl_keep", d, {29'h0000_0000, pc});
    // Erase without and with the configuration store
    prog_u.pulse(3'h1);
    @(posedge aclk);
    check("unprot_erase", program_mem_erase, 1'h1);
    prog_u.pulse(3'h2);
    rd(a_w2);
    check("bulk_blank", d, 32'h0000_3FFF);
    reload();
    rd(`STAT_ADDR);
    check("blank_status", d, stat(`CW_BLANK, `CW_BLANK, c, sl));
    // Mid-run reset: words programmed since the last load take effect on release
    prog_u.put(1'h0, w1);
    prog_u.put(1'h1, w2);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("rst_valid", settings_valid, 1'h0);
    repeat (3) @(posedge aclk);
    rd(`STAT_ADDR);
    check("rst_status", d, stat(w1, w2, 3'h0, sl));
    results();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #2000000;
    bad_count++;
    results();
  end
endmodule // config_word_decoder_tb_top
`default_nettype wire
